// File: rhd_ctrl.sv
// Chip reset release, warm reset, halt and debug control, top level.
//
// How it works
// [R1] A load releases every core object from reset on one and the same edge.
// [R2] A warm reset pulses the reset of only the objects named in its mask.
// [R3] Every load and warm reset clears the shared-bus registers of the
//      objects it touches.
// [R4] Adjacent-link registers revert on warm reset only when enabled.
// [R5] The test port offers standard boundary scan with capture and update.
// [R6] The test port can read object registers and internal memory.
// [R7] With deferred start chosen, a load waits for a start command.
// [R8] A stop command from the test port halts the application.
// [R9] The one-bit breakpoint input halts the application.
// [R10] The halt is reached exactly 13 core cycles after the breakpoint.
// [R11] Application logic alone decides when the breakpoint is driven.
// [R12] While the override is set, the breakpoint input is ignored.
// [R13] The periphery is enabled before any core object leaves reset.
// [R14] A failed image checksum blocks start and shows in status.
// [R15] Once halted, the device stays so until a start or a new load.
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module rhd_ctrl
   import rhd_pkg::*;
#(
   parameter int NOBJ   = 4,
   parameter int MEM_AW = 8
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic [3:0]      wb_adr_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic            wb_we_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   output logic                 wb_ack_o,
   input  wire logic            crcOk,
   input  wire logic            bkpt,
   output logic      [NOBJ-1:0] objRstN,
   output logic      [NOBJ-1:0] sharedBusClr,
   output logic      [NOBJ-1:0] adjLinkRevert,
   output logic                 periphEn,
   output logic                 appRun,
   output logic                 halted,
   input  wire logic            tck,
   input  wire logic            trst_n,
   input  wire logic            tms,
   input  wire logic            tdi,
   output logic                 tdo,
   output logic                 tdoOe,
   input  wire logic [DR_W-1:0] bsIn,
   output logic      [DR_W-1:0] bsOut,
   output logic                 extestEn
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   rhd_dbg_if dbg ();

   rhd_state_e        state_q, state_d;
   logic [1:0]        ctrl_q;
   logic [NOBJ-1:0]   warmMask_q;
   logic [NOBJ-1:0]   objRstN_q, objRstN_d;
   logic [NOBJ-1:0]   busClr_q, busClr_d;
   logic [NOBJ-1:0]   adjRev_q, adjRev_d;
   logic [PER_CW-1:0] perCnt_q;
   logic [BK_CW-1:0]  bkCnt_q, bkCnt_d;
   logic              ovr_q, periph_q, run_q, halt_q;
   logic              c1_q, c2_q, c3_q, done_q, ackTgl_q;
   logic [DR_W-1:0]   res_q;
   logic              ack_q;
   logic [31:0]       dat_q;
   logic [DAT_W-1:0]  memRdata;

   // Status byte, seen both by the bus and by the test port.
   function automatic logic [ST_W-1:0] statVec(rhd_state_e s,
                                               logic ovr, logic pend);
      logic [ST_W-1:0] v;
      v          = '0;
      v[ST_RUN]  = s == S_RUN;
      v[ST_HALT] = s == S_HALT;
      v[ST_CRC]  = s == S_CRCERR;
      v[ST_OVR]  = ovr;
      v[ST_WAIT] = s == S_WAIT;
      v[ST_BKPT] = pend;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Test access port and image memory.

   rhd_tap u_tap (
      .tck      (tck),
      .trst_n   (trst_n),
      .tms      (tms),
      .tdi      (tdi),
      .tdo      (tdo),
      .tdoOe    (tdoOe),
      .bsIn     (bsIn),
      .bsOut    (bsOut),
      .extestEn (extestEn),
      .dbg      (dbg.tap)
   );

   // The command word is stable while its toggle is in flight.
   wire [3:0]  cmdOp  = dbg.cmdWord[OP_LSB +: 4];
   wire        cmdNew = c2_q ^ c3_q;
   wire        memWe  = cmdNew && cmdOp == OP_MEMWR;

   rhd_mem #(.AW(MEM_AW), .DW(DAT_W)) u_mem (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (memWe),
      .addr  (dbg.cmdWord[ADR_LSB +: MEM_AW]),
      .wdata (dbg.cmdWord[DAT_W-1:0]),
      .rdata (memRdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command crossing from the test clock.

   // Toggle synchroniser; only the second and third stages are compared.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c1_q <= 1'b0;
         c2_q <= 1'b0;
         c3_q <= 1'b0;
      end else begin
         c1_q <= dbg.cmdTgl;
         c2_q <= c1_q;
         c3_q <= c2_q;
      end
   end

   // Command decode.
   wire startCmd = cmdNew && cmdOp == OP_START;
   wire stopCmd  = cmdNew && cmdOp == OP_STOP;
   wire loadCmd  = cmdNew && cmdOp == OP_LOAD;

   // The answer is sent one cycle on, once the memory read has landed.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q   <= 1'b0;
         ackTgl_q <= 1'b0;
         res_q    <= '0;
      end else begin
         done_q <= cmdNew;
         if (done_q) begin
            res_q    <= {8'h00, statVec(state_q, ovr_q, bkCnt_q != '0),
                         memRdata}; // R6 R14
            ackTgl_q <= !ackTgl_q;
         end
      end
   end

   assign dbg.ackTgl  = ackTgl_q;
   assign dbg.resWord = res_q;

   ////////////////////////////////////////////////////////////////////////
   // Register bus slave.

   wire wbReq  = wb_cyc_i && wb_stb_i && !ack_q;
   wire wbWr   = wbReq && wb_we_i && wb_sel_i[0];
   wire ctrlWr = wbWr && wb_adr_i == OFS_CTRL;
   wire iplGo  = loadCmd || (ctrlWr && wb_dat_i[CTRL_LOAD]);
   wire live   = !(state_q inside {S_IDLE, S_PERIPH});
   wire warmGo = wbWr && wb_adr_i == OFS_WARM && live;
   wire [NOBJ-1:0] mask = wb_dat_i[NOBJ-1:0];

   // Read selection; unmapped offsets answer with zero.
   wire [31:0] rdMux =
      (wb_adr_i == OFS_CTRL) ? {30'h0, ctrl_q} :
      (wb_adr_i == OFS_WARM) ? {{(32 - NOBJ){1'b0}}, warmMask_q} :
      (wb_adr_i == OFS_STAT) ?
         {24'h0, statVec(state_q, ovr_q, bkCnt_q != '0)} : 32'h0;

   // Every request is answered on the following edge, for one cycle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q      <= 1'b0;
         dat_q      <= '0;
         ctrl_q     <= CTRL_RST;
         warmMask_q <= '0;
      end else begin
         ack_q <= wbReq;
         if (wbReq) begin
            dat_q <= rdMux;
         end
         if (ctrlWr) begin
            ctrl_q <= {wb_dat_i[CTRL_REVERT], wb_dat_i[CTRL_DEFER]};
         end
         if (warmGo) begin
            warmMask_q <= mask;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////
   // Load sequence and halt control.

   // A breakpoint is taken only in the run state, with no override set.
   wire bkTake = state_q == S_RUN && bkpt && !ovr_q && bkCnt_q == '0; // R9 R12
   wire perDone = perCnt_q == PER_CW'(PERIPH_CYC - 1);

   // Next state; a new load overrides anything in progress.
   always_comb begin
      state_d = state_q;
      if (iplGo) begin
         state_d = S_PERIPH; // R13
      end else begin
         case (state_q)
            S_IDLE:   state_d = S_IDLE;
            S_PERIPH: state_d = perDone ? S_CORE : S_PERIPH; // R13
            S_CORE:   state_d = S_CHECK;
            S_CHECK:  state_d = !crcOk ? S_CRCERR : // R14
                                ctrl_q[CTRL_DEFER] ? S_WAIT : S_RUN; // R7
            S_WAIT:   state_d = startCmd ? S_RUN :
                                stopCmd ? S_HALT : S_WAIT; // R7
            S_RUN: begin
               if (stopCmd ||
                   bkCnt_q == BK_CW'(BKPT_CYC - 1)) begin
                  state_d = S_HALT; // R8 R10
               end
            end
            S_HALT:   state_d = startCmd ? S_RUN : S_HALT; // R15
            S_CRCERR: state_d = S_CRCERR; // R14
            default:  state_d = S_IDLE;
         endcase
      end
   end

   // Breakpoint counter; once started it counts up to the halt unless the run ends.
   always_comb begin
      if (bkTake) begin
         bkCnt_d = BK_CW'(1); // R10
      end else if (bkCnt_q != '0 && state_q == S_RUN && state_d == S_RUN) begin
         bkCnt_d = bkCnt_q + BK_CW'(1);
      end else begin
         bkCnt_d = '0;
      end
   end

   // Object resets. Objects are held during load, all released together
   // on entry to the core step, and a warm reset pulses only its mask.
   wire coreRel = state_q == S_PERIPH && state_d == S_CORE;
   assign objRstN_d = (state_d inside {S_IDLE, S_PERIPH}) ? '0 : // R1
                      warmGo ? ~mask : '1; // R2
   assign busClr_d  = coreRel ? '1 : warmGo ? mask : '0; // R3
   // On warm reset, adjacent links keep their contents unless revert is enabled; a load reverts them all.
   assign adjRev_d  = coreRel ? '1 :
                      (warmGo && ctrl_q[CTRL_REVERT]) ? mask : '0; // R4

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= S_IDLE;
         objRstN_q <= '0;
         busClr_q  <= '0;
         adjRev_q  <= '0;
         bkCnt_q   <= '0;
         run_q     <= 1'b0;
         halt_q    <= 1'b0;
         periph_q  <= 1'b0;
      end else begin
         state_q   <= state_d;
         objRstN_q <= objRstN_d;
         busClr_q  <= busClr_d;
         adjRev_q  <= adjRev_d;
         bkCnt_q   <= bkCnt_d;
         run_q     <= state_d == S_RUN;
         halt_q    <= state_d == S_HALT;
         periph_q  <= state_d != S_IDLE; // R13
      end
   end

   // Periphery settle counter and breakpoint override.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         perCnt_q <= '0;
         ovr_q    <= 1'b0;
      end else begin
         perCnt_q <= (state_q == S_PERIPH && !iplGo) ?
                     perCnt_q + PER_CW'(1) : '0;
         if (cmdNew && cmdOp == OP_OVRON) begin
            ovr_q <= 1'b1; // R12
         end else if (cmdNew && cmdOp == OP_OVROFF) begin
            ovr_q <= 1'b0;
         end
      end
   end

   assign objRstN       = objRstN_q;
   assign sharedBusClr  = busClr_q;
   assign adjLinkRevert = adjRev_q;
   assign periphEn      = periph_q;
   assign appRun        = run_q;
   assign halted        = halt_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence bkSeen;
      bkTake && !iplGo;
   endsequence

   sequence haltLater;
      ##12 !halt_q ##1 halt_q;
   endsequence

   a_ipl_release: // R1
      assert property ($past(objRstN_q) == '0 && objRstN_q != '0
                       |-> objRstN_q == '1)
      else $error("core objects left reset on different edges");

   a_warm_mask: // R2
      assert property (warmGo |=> objRstN_q == ~$past(mask) ##1
                       objRstN_q == '1)
      else $error("warm reset did not follow its mask");

   a_bus_clear: // R3
      assert property (warmGo && !coreRel |=> busClr_q == $past(mask))
      else $error("shared bus registers not cleared by warm reset");

   a_adj_keep: // R4
      assert property (warmGo && !ctrl_q[CTRL_REVERT] |=> adjRev_q == '0)
      else $error("adjacent links reverted without being enabled");

   a_defer_wait: // R7
      assert property (state_q == S_CHECK && crcOk && ctrl_q[CTRL_DEFER]
                       && !iplGo |=> !run_q [*2])
      else $error("deferred load started without a start command");

   a_stop_halt: // R8
      assert property (state_q == S_RUN && stopCmd && !iplGo |=> halt_q)
      else $error("stop command did not halt");

   a_bkpt_halt: // R10
      assert property (disable iff (!rst_n || iplGo || startCmd)
                       bkSeen and !stopCmd |-> haltLater)
      else $error("breakpoint halt not exactly thirteen cycles later");

   a_ovr_ignore: // R12
      assert property (ovr_q && bkpt && bkCnt_q == '0 |=> bkCnt_q == '0)
      else $error("breakpoint taken while overridden");

   a_periph_first: // R13
      assert property ($rose(objRstN_q[0]) && !warmGo |-> periph_q &&
                       $past(periph_q, 2))
      else $error("core released before periphery enabled");

   a_crc_block: // R14
      assert property (state_q == S_CHECK && !crcOk && !iplGo
                       |=> !run_q && state_q == S_CRCERR)
      else $error("application started after a bad checksum");

   a_halt_stay: // R15
      assert property (halt_q && !startCmd && !iplGo |=> halt_q)
      else $error("halt released without start or load");
endmodule

// File: rhd_pkg.sv
// Shared constants and types for the reset, halt and debug controller.
package rhd_pkg;
   // Core clock rate and derived timing counts.
   localparam int CORE_MHZ   = 100;
   localparam int BKPT_CYC   = 13;
   localparam int PERIPH_NS  = 160;
   localparam int PERIPH_CYC = (PERIPH_NS * CORE_MHZ + 999) / 1000;
   localparam int PER_CW     = $clog2(PERIPH_CYC + 1);
   localparam int BK_CW      = $clog2(BKPT_CYC + 1);

   // Register byte offsets on the bus.
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_WARM = 4'h4;
   localparam logic [3:0] OFS_STAT = 4'h8;

   // Control register fields and reset value.
   localparam int         CTRL_DEFER  = 0;
   localparam int         CTRL_REVERT = 1;
   localparam int         CTRL_LOAD   = 2;
   localparam logic [1:0] CTRL_RST    = 2'h0;

   // Status fields, shared by the bus and the debug port.
   localparam int ST_W    = 8;
   localparam int ST_RUN  = 0;
   localparam int ST_HALT = 1;
   localparam int ST_CRC  = 2;
   localparam int ST_OVR  = 3;
   localparam int ST_WAIT = 4;
   localparam int ST_BKPT = 5;

   // Test access port instructions and data register layout.
   localparam int               IR_W      = 4;
   localparam logic [IR_W-1:0]  IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0]  IR_SAMPLE = 4'h1;
   localparam logic [IR_W-1:0]  IR_IDCODE = 4'h2;
   localparam logic [IR_W-1:0]  IR_DEBUG  = 4'h8;
   localparam logic [IR_W-1:0]  IR_BYPASS = 4'hF;
   localparam logic [IR_W-1:0]  IR_CAPT   = 4'h1;
   localparam int               DR_W      = 32;
   localparam int               OP_LSB    = 28;
   localparam int               ADR_LSB   = 16;
   localparam int               DAT_W     = 16;

   // Debug command opcodes.
   localparam logic [3:0] OP_START  = 4'h1;
   localparam logic [3:0] OP_STOP   = 4'h2;
   localparam logic [3:0] OP_OVRON  = 4'h3;
   localparam logic [3:0] OP_OVROFF = 4'h4;
   localparam logic [3:0] OP_MEMWR  = 4'h5;
   localparam logic [3:0] OP_MEMRD  = 4'h6;
   localparam logic [3:0] OP_LOAD   = 4'h7;

   typedef enum logic [2:0] {
      S_IDLE, S_PERIPH, S_CORE, S_CHECK, S_WAIT, S_RUN, S_HALT, S_CRCERR
   } rhd_state_e;
endpackage

// File: rhd_dbg_if.sv
// Crossing link between the test access port and the core-clock logic.
`timescale 1ns/1ps
interface rhd_dbg_if;
   import rhd_pkg::*;
   logic [DR_W-1:0] cmdWord;
   logic            cmdTgl;
   logic            ackTgl;
   logic [DR_W-1:0] resWord;
   modport tap  (output cmdWord, output cmdTgl, input ackTgl, input resWord);
   modport core (input cmdWord, input cmdTgl, output ackTgl, output resWord);
endinterface

// File: rhd_mem.sv
// Object register and RAM image store with registered read data.
`timescale 1ns/1ps
module rhd_mem #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] rdata_q;

   // The array has no reset; only the read port register does.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem[addr];
      end
   end

   assign rdata = rdata_q;
endmodule

// File: rhd_tap.sv
// Test access port: state machine, instructions, scan and debug registers.
`timescale 1ns/1ps
module rhd_tap
   import rhd_pkg::*;
#(
   parameter logic [31:0] IDCODE = 32'h0000_0001 // Arbitrary value.
) (
   input  wire logic            tck,
   input  wire logic            trst_n,
   input  wire logic            tms,
   input  wire logic            tdi,
   output logic                 tdo,
   output logic                 tdoOe,
   input  wire logic [DR_W-1:0] bsIn,
   output logic      [DR_W-1:0] bsOut,
   output logic                 extestEn,
   rhd_dbg_if.tap               dbg
);
   typedef enum logic [3:0] {
      T_RESET, T_IDLE, T_SELDR, T_CAPDR, T_SHDR, T_EX1DR, T_PADR,
      T_EX2DR, T_UPDR, T_SELIR, T_CAPIR, T_SHIR, T_EX1IR, T_PAIR,
      T_EX2IR, T_UPIR
   } rhd_tap_e;

   rhd_tap_e        st_q, st_d;
   logic [IR_W-1:0] irSh_q, ir_q;
   logic [DR_W-1:0] sh_q, bsUpd_q, cmdWord_q;
   logic            byp_q, cmdTgl_q, ack1_q, ack2_q;
   logic            tdo_q, tdoOe_q, extest_q;

   // Controller walk, driven by tms alone.
   always_comb begin
      case (st_q)
         T_RESET: st_d = tms ? T_RESET : T_IDLE;
         T_IDLE:  st_d = tms ? T_SELDR : T_IDLE;
         T_SELDR: st_d = tms ? T_SELIR : T_CAPDR;
         T_CAPDR: st_d = tms ? T_EX1DR : T_SHDR;
         T_SHDR:  st_d = tms ? T_EX1DR : T_SHDR;
         T_EX1DR: st_d = tms ? T_UPDR  : T_PADR;
         T_PADR:  st_d = tms ? T_EX2DR : T_PADR;
         T_EX2DR: st_d = tms ? T_UPDR  : T_SHDR;
         T_UPDR:  st_d = tms ? T_SELDR : T_IDLE;
         T_SELIR: st_d = tms ? T_RESET : T_CAPIR;
         T_CAPIR: st_d = tms ? T_EX1IR : T_SHIR;
         T_SHIR:  st_d = tms ? T_EX1IR : T_SHIR;
         T_EX1IR: st_d = tms ? T_UPIR  : T_PAIR;
         T_PAIR:  st_d = tms ? T_EX2IR : T_PAIR;
         T_EX2IR: st_d = tms ? T_UPIR  : T_SHIR;
         T_UPIR:  st_d = tms ? T_SELDR : T_IDLE;
         default: st_d = T_RESET;
      endcase
   end

   // A command is refused while the previous one is still in flight.
   wire busy     = ack2_q != cmdTgl_q;
   wire isBypass = !(ir_q inside {IR_EXTEST, IR_SAMPLE, IR_IDCODE,
                                  IR_DEBUG});

   // State, instruction and data registers all move on the rising edge.
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         st_q      <= T_RESET;
         irSh_q    <= '0;
         ir_q      <= IR_IDCODE;
         sh_q      <= '0;
         byp_q     <= 1'b0;
         bsUpd_q   <= '0;
         cmdWord_q <= '0;
         cmdTgl_q  <= 1'b0;
         ack1_q    <= 1'b0;
         ack2_q    <= 1'b0;
         extest_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         ack1_q <= dbg.ackTgl;
         ack2_q <= ack1_q;
         extest_q <= ir_q == IR_EXTEST; // R5
         case (st_q)
            T_RESET: ir_q   <= IR_IDCODE;
            T_CAPIR: irSh_q <= IR_CAPT;
            T_SHIR:  irSh_q <= {tdi, irSh_q[IR_W-1:1]};
            T_UPIR:  ir_q   <= irSh_q;
            T_CAPDR: begin
               byp_q <= 1'b0;
               case (ir_q)
                  IR_IDCODE: sh_q <= IDCODE;
                  IR_DEBUG:  sh_q <= {busy, dbg.resWord[DR_W-2:0]}; // R6
                  default:   sh_q <= bsIn; // R5
               endcase
            end
            T_SHDR: begin
               byp_q <= tdi;
               sh_q  <= {tdi, sh_q[DR_W-1:1]};
            end
            T_UPDR: begin
               if (ir_q == IR_EXTEST || ir_q == IR_SAMPLE) begin
                  bsUpd_q <= sh_q; // R5
               end
               if (ir_q == IR_DEBUG && !busy) begin
                  cmdWord_q <= sh_q;
                  cmdTgl_q  <= !cmdTgl_q;
               end
            end
            default: ;
         endcase
      end
   end

   // Test data out changes on the falling edge, as the scan standard asks.
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_q   <= 1'b0;
         tdoOe_q <= 1'b0;
      end else begin
         tdoOe_q <= st_q == T_SHDR || st_q == T_SHIR;
         tdo_q   <= (st_q == T_SHIR) ? irSh_q[0] :
                    isBypass ? byp_q : sh_q[0];
      end
   end

   assign tdo         = tdo_q;
   assign tdoOe       = tdoOe_q;
   assign bsOut       = bsUpd_q;
   assign extestEn    = extest_q;
   assign dbg.cmdWord = cmdWord_q;
   assign dbg.cmdTgl  = cmdTgl_q;
endmodule

// File: rhd_jtag_host.sv
// JTAG host model driving the test access port.
`timescale 1ns/1ps
module rhd_jtag_host (
   output logic      tck,
   output logic      trstN,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // The test clock stands still low between pulses.
   initial begin
      tck = 1'b0;
      trstN = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One 6 ns test clock pulse; tdo is taken on the rise.
   task automatic pulse(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #3 tck = 1'b1;
      q = tdo;
      #3 tck = 1'b0;
   endtask
   // Idle pulses; tdi toggles since nothing reads it there.
   task automatic idle(input int n);
      logic q;
      repeat (n) pulse(1'b0, ~tdi, q);
   endtask
   // Full IR or DR scan from Idle back to Idle, LSB first.
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      pulse(1'b1, ~tdi, q);
      if (ir) pulse(1'b1, ~tdi, q);
      pulse(1'b0, ~tdi, q);
      pulse(1'b0, ~tdi, q);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], q);
         dout[i] = q;
      end
      pulse(1'b1, ~tdi, q);
      pulse(1'b0, ~tdi, q);
   endtask
   // Release the port reset, then settle in Idle.
   task automatic resetTap;
      trstN = 1'b0;
      #6 trstN = 1'b1;
      idle(2);
   endtask
endmodule

// File: test_reset_halt_debug_control.sv
// Self-checking bench for the reset, halt and debug controller.
`timescale 1ns/1ps
module test_reset_halt_debug_control;
   import rhd_pkg::*;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
 fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
 $time, a, b); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 100) begin \
 @(posedge clk); #1; n++; end if (!(c)) fail_count++; end
   logic        clk, rst_n, wbWe, wbCyc, wbStb, wbAck, crcOk, bkpt;
   logic        periphEn, appRun, halted, tck, trstN, tms, tdi, tdo, extest;
   logic [3:0]  wbAdr, wbSel, objRstN, sbClr, adjRev, mask;
   logic [31:0] wbDatI, wbDatO, bsIn, bsOut, rd, capt, d;
   logic [11:0] madr, snap;
   logic [15:0] mdat;
   int          fail_count, total_checks, n;

   rhd_ctrl uut (.clk(clk), .rst_n(rst_n), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_sel_i(wbSel),
      .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_ack_o(wbAck), .crcOk(crcOk), .bkpt(bkpt), .objRstN(objRstN),
      .sharedBusClr(sbClr), .adjLinkRevert(adjRev), .periphEn(periphEn),
      .appRun(appRun), .halted(halted), .tck(tck), .trst_n(trstN),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(), .bsIn(bsIn),
      .bsOut(bsOut), .extestEn(extest));
   rhd_jtag_host host (.tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi),
      .tdo(tdo));

   ////////////////////////////////////////////////////////////////////////
   // Core clock at 100 MHz.
   always #5 clk = ~clk;

   // Classic single Wishbone cycle; waits for ack without assuming latency.
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] dw);
      int t;
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, dw};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1 && t < 50);
      if (wbAck !== 1'b1) fail_count++;
      rd = wbDatO;
      // Warm reset pulses stand only in the ack cycle, so take them here.
      snap = {objRstN, sbClr, adjRev};
      {wbCyc, wbStb} <= 2'b00;
   endtask
   // Debug command; the result shows in the capture of the next one.
   task automatic dbg(input logic [3:0] op, input logic [11:0] a,
                      input logic [15:0] dw);
      host.scan(1'b0, 32, {op, a, dw}, capt);
      repeat (4) @(posedge clk);
      host.idle(4);
      repeat (6) @(posedge clk);
      #1;
   endtask
   // One-cycle breakpoint pulse driven by the application side.
   task automatic pulseBkpt;
      @(posedge clk);
      bkpt <= 1'b1;
      @(posedge clk);
      bkpt <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, scan, load, warm reset, halts and loads.
   initial begin
      void'($urandom(50261));
      {clk, rst_n, wbWe, wbCyc, wbStb, bkpt, wbAdr, wbDatI} = '0;
      wbSel = 4'hF;
      crcOk = 1'b1;
      bsIn = $urandom;
      d = $urandom;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      `CHK(objRstN, 4'h0)
      host.resetTap;
      host.scan(1'b0, 32, 32'h0, capt);
      `CHK(capt, 32'h0000_0001)
      host.scan(1'b1, 4, IR_SAMPLE, capt);
      `CHK(capt[3:0], IR_CAPT)
      host.scan(1'b0, 32, d, capt);
      `CHK(capt, bsIn)
      `CHK(bsOut, d)
      host.scan(1'b1, 4, IR_EXTEST, capt);
      host.idle(1);
      `CHK(extest, 1'b1)
      host.scan(1'b1, 4, IR_DEBUG, capt);
      wb(1'b0, 4'hC, 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b1, OFS_CTRL, 32'h4);
      `WAITC(periphEn === 1'b1)
      `CHK(objRstN, 4'h0)
      `WAITC(objRstN !== 4'h0)
      `CHK({objRstN, sbClr, adjRev}, 12'hFFF)
      `WAITC(appRun === 1'b1)
      `CHK(appRun, 1'b1)
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, OFS_CTRL, 32'(k * 2));
         mask = 4'($urandom_range(1, 15));
         wb(1'b1, OFS_WARM, {28'h0, mask});
         `CHK(snap[11:8], ~mask)
         `CHK(snap[7:4], mask)
         `CHK(snap[3:0], k ? mask : 4'h0)
         #1;
         `CHK(objRstN, 4'hF)
      end
      pulseBkpt;
      // The pulse was raised one edge before the task returned.
      n = 1;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (halted !== 1'b1 && n < 40);
      `CHK(n, 13)
      `CHK(appRun, 1'b0)
      repeat (20) @(posedge clk);
      `CHK(halted, 1'b1)
      dbg(OP_START, 12'h0, 16'h0);
      `CHK({halted, appRun}, 2'b01)
      dbg(OP_OVRON, 12'h0, 16'h0);
      pulseBkpt;
      repeat (20) @(posedge clk);
      `CHK(halted, 1'b0)
      dbg(OP_OVROFF, 12'h0, 16'h0);
      dbg(OP_STOP, 12'h0, 16'h0);
      `CHK(halted, 1'b1)
      madr = 12'($urandom_range(0, 255));
      mdat = 16'($urandom);
      dbg(OP_MEMWR, madr, mdat);
      dbg(OP_MEMRD, madr, 16'h0);
      dbg(OP_OVROFF, 12'h0, 16'h0);
      `CHK(capt[15:0], mdat)
      `CHK(capt[ADR_LSB + ST_HALT], 1'b1)
      wb(1'b1, OFS_CTRL, 32'h5);
      repeat (40) @(posedge clk);
      wb(1'b0, OFS_STAT, 32'h0);
      `CHK({appRun, rd[ST_WAIT]}, 2'b01)
      dbg(OP_START, 12'h0, 16'h0);
      `CHK(appRun, 1'b1)
      crcOk <= 1'b0;
      dbg(OP_LOAD, 12'h0, 16'h0);
      repeat (40) @(posedge clk);
      wb(1'b0, OFS_STAT, 32'h0);
      `CHK({appRun, rd[ST_CRC]}, 2'b01)
      close_out;
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #300000;
      fail_count++;
      close_out;
   end
endmodule
